// *** logic/spi_map.vh ***
`ifndef SPI_MAP_VH
`define SPI_MAP_VH
// instruction class codes
`define SPI_CLS_W        2
`define SPI_CLS_INT      2'h0
`define SPI_CLS_SIMD     2'h1
`define SPI_CLS_FP       2'h2
// queue and parse limits
`define SPI_QUEUE_DEPTH  4
`define SPI_LONG_BYTES   4'h7
// multiplier pipe stages
`define SPI_MUL_STAGES   3
// parsed instruction field layout
`define SPI_F_CLS_LO     0
`define SPI_F_CLS_HI     1
`define SPI_F_SHF        2
`define SPI_F_MUL        3
`define SPI_F_MEM        4
`define SPI_F_EMPTY      5
`define SPI_F_UPAIR      6
`define SPI_F_VPAIR      7
`define SPI_F_DST_LO     8
`define SPI_F_DST_HI     10
`define SPI_F_SRC_LO     11
`define SPI_F_SRC_HI     13
`define SPI_F_FIRST      14
`define SPI_F_OP_LO      15
`define SPI_INSTR_W      31
`endif

// *** logic/spi_parse.v ***
`timescale 1ns/1ps
`default_nettype none
`include "spi_map.vh"
// splits raw instruction records into queue words; prefix bits fold into the opcode
module spi_parse (
    // raw records from prefetch
    input  wire [1:0]  raw_valid,
    input  wire [3:0]  raw_len0,
    input  wire [3:0]  raw_len1,
    input  wire [3:0]  raw_prefix0,
    input  wire [3:0]  raw_prefix1,
    input  wire [30:0] raw_instr0,
    input  wire [30:0] raw_instr1,
    // queue push side
    output reg  [1:0]  push_cnt,
    output wire [30:0] push_instr0,
    output wire [30:0] push_instr1
);
    wire long0 = raw_len0 > `SPI_LONG_BYTES;
    wire long1 = raw_len1 > `SPI_LONG_BYTES;
    // prefixes decoded before queue entry
    assign push_instr0 = {raw_instr0[30:27] | raw_prefix0, raw_instr0[26:0]};
    assign push_instr1 = {raw_instr1[30:27] | raw_prefix1, raw_instr1[26:0]};
    always @* begin
        if (!raw_valid[0])
            push_cnt = 2'h0;
        else if (raw_valid[1] && !long0 && !long1)
            push_cnt = 2'h2;
        else
            push_cnt = 2'h1;
    end
endmodule
`default_nettype wire

// *** logic/spi_pair_rules.v ***
`timescale 1ns/1ps
`default_nettype none
`include "spi_map.vh"
// pure pairing decision for an older/younger candidate pair
module spi_pair_rules (
    input  wire [30:0] older,
    input  wire [30:0] younger,
    input  wire        task_switched_bit,
    input  wire        emulation_bit,
    output wire        can_pair
);
    wire [1:0] cu = older[`SPI_F_CLS_HI:`SPI_F_CLS_LO];
    wire [1:0] cv = younger[`SPI_F_CLS_HI:`SPI_F_CLS_LO];
    wire su = cu == `SPI_CLS_SIMD;
    wire sv = cv == `SPI_CLS_SIMD;
    wire iu = cu == `SPI_CLS_INT;
    wire iv = cv == `SPI_CLS_INT;
    wire fu = cu == `SPI_CLS_FP;
    wire fv = cv == `SPI_CLS_FP;
    wire [2:0] ud = older[`SPI_F_DST_HI:`SPI_F_DST_LO];
    wire dep = ud == younger[`SPI_F_DST_HI:`SPI_F_DST_LO] ||
               ud == younger[`SPI_F_SRC_HI:`SPI_F_SRC_LO];
    reg ok;
    always @* begin
        ok = 1'b1;
        if ((su && fv) || (fu && sv))
            ok = 1'b0;
        if (older[`SPI_F_EMPTY] || younger[`SPI_F_EMPTY])
            ok = 1'b0;
        if (sv && (task_switched_bit || emulation_bit))
            ok = 1'b0;
        if (sv && younger[`SPI_F_MEM])
            ok = 1'b0;
        if (su && sv) begin
            if (older[`SPI_F_SHF] && younger[`SPI_F_SHF])
                ok = 1'b0;
            if (older[`SPI_F_MUL] && younger[`SPI_F_MUL])
                ok = 1'b0;
            if (dep)
                ok = 1'b0;
        end
        if (iu && sv && (younger[`SPI_F_FIRST] || !older[`SPI_F_UPAIR]))
            ok = 1'b0;
        if (su && iv && (older[`SPI_F_MEM] || !younger[`SPI_F_VPAIR]))
            ok = 1'b0;
    end
    assign can_pair = ok;
endmodule
`default_nettype wire

// *** logic/spi_issue_ctl.v ***
// Summary of operation
// - four-slot queue between parse and decode
// - empty queue bypasses straight into decode
// - parse pushes up to two per cycle
// - decode pulls candidate pairs, two max
// - lone visible instruction issues unpaired
// - instruction over seven bytes pushes alone
// - queue hides parse stalls; empty starves
// - pipe stall holds all younger instructions
// - parse splits records and decodes prefixes
// - second decode reads source operands
// - single-clock ops execute, write next stage
// - multiply: three stages then write stage
// - simd pairs simd or integer, never float
// - no two simd shifter users paired
// - no two multiplier users paired
// - memory/integer-file simd only first pipe
// - no simd-simd pairing on first-pipe destination dependency
// - empty-state instruction always issues alone
// - control bits keep simd off second pipe
// - integer-then-simd pairing needs two conditions
// - simd-then-integer pairing needs two conditions
`timescale 1ns/1ps
`default_nettype none
`include "spi_map.vh"
module spi_issue_ctl #(
    parameter DEPTH = `SPI_QUEUE_DEPTH,
    parameter IW    = `SPI_INSTR_W
) (
    // clock and reset
    input  wire          ref_clk,
    input  wire          rst,
    // raw records from prefetch
    input  wire [1:0]    raw_valid,
    input  wire [3:0]    raw_len0,
    input  wire [3:0]    raw_len1,
    input  wire [3:0]    raw_prefix0,
    input  wire [3:0]    raw_prefix1,
    input  wire [IW-1:0] raw_instr0,
    input  wire [IW-1:0] raw_instr1,
    output wire [1:0]    raw_accept,
    // control bits
    input  wire          task_switched_bit,
    input  wire          emulation_bit,
    // pipe stall from execute
    input  wire          pipe_stall,
    // operand read port
    output wire [2:0]    src_addr_u,
    output wire [2:0]    src_addr_v,
    input  wire [63:0]   src_data_u,
    input  wire [63:0]   src_data_v,
    // execute outputs
    output reg           exec_u_valid_reg,
    output reg           exec_v_valid_reg,
    output reg  [IW-1:0] exec_u_instr_reg,
    output reg  [IW-1:0] exec_v_instr_reg,
    output reg  [63:0]   exec_u_src_reg,
    output reg  [63:0]   exec_v_src_reg,
    // result writes
    output reg           alu_write_valid_reg,
    output reg  [2:0]    alu_write_dst_reg,
    output reg           alu_v_write_valid_reg,
    output reg  [2:0]    alu_v_write_dst_reg,
    output reg           mul_write_valid_reg,
    output reg  [2:0]    mul_write_dst_reg,
    // status
    output wire [2:0]    queue_count,
    output wire          decode_starved
);
    wire [1:0]    push_cnt;
    wire [IW-1:0] push_i0;
    wire [IW-1:0] push_i1;

    spi_parse u_parse (
        .raw_valid   (raw_valid),
        .raw_len0    (raw_len0),
        .raw_len1    (raw_len1),
        .raw_prefix0 (raw_prefix0),
        .raw_prefix1 (raw_prefix1),
        .raw_instr0  (raw_instr0),
        .raw_instr1  (raw_instr1),
        .push_cnt    (push_cnt),
        .push_instr0 (push_i0),
        .push_instr1 (push_i1)
    );

    // queue storage, slot 0 is oldest
    reg [IW-1:0] q_mem [0:DEPTH-1];
    reg [2:0]    q_cnt_reg;
    reg [2:0]    q_cnt_next;

    // decode-first stage registers
    reg          d1_u_valid_reg;
    reg          d1_v_valid_reg;
    reg [IW-1:0] d1_u_reg;
    reg [IW-1:0] d1_v_reg;

    // decode-second stage registers
    reg          d2_u_valid_reg;
    reg          d2_v_valid_reg;
    reg [IW-1:0] d2_u_reg;
    reg [IW-1:0] d2_v_reg;

    // a stall freezes queue pulls and both decode stages
    wire hold = pipe_stall;

    // view of queue plus bypassed pushes, oldest first
    reg [IW-1:0] view0;
    reg [IW-1:0] view1;
    reg [2:0]    avail;
    always @* begin
        avail = q_cnt_reg + {1'b0, push_cnt};
        view0 = q_mem[0];
        view1 = q_mem[1];
        if (q_cnt_reg == 3'h0) begin
            view0 = push_i0;
            view1 = push_i1;
        end else if (q_cnt_reg == 3'h1) begin
            view1 = push_i0;
        end
    end

    wire can_pair;
    // pairing looks only at the two oldest visible instructions
    spi_pair_rules u_rules (
        .older             (view0),
        .younger           (view1),
        .task_switched_bit (task_switched_bit),
        .emulation_bit     (emulation_bit),
        .can_pair          (can_pair)
    );

    // pulls into decode-first: zero when held or starved
    reg [1:0] pull_cnt;
    always @* begin
        if (hold || avail == 3'h0)
            pull_cnt = 2'h0;
        else if (avail == 3'h1)
            pull_cnt = 2'h1;
        else if (can_pair)
            pull_cnt = 2'h2;
        // younger of a failed pair is the oldest next cycle
        else
            pull_cnt = 2'h1;
    end

    // accept only what fits after this cycle's pulls
    // counting the pulls lets a full queue still take a pair
    wire [3:0] room = DEPTH[3:0] - {1'b0, q_cnt_reg} + {2'b00, pull_cnt};
    wire [1:0] acc_cnt = (room >= {2'b00, push_cnt}) ? push_cnt :
                         (room == 4'h1 ? 2'h1 : 2'h0);
    assign raw_accept = (acc_cnt == 2'h2) ? 2'h3 : (acc_cnt == 2'h1 ? 2'h1 : 2'h0);
    assign queue_count = q_cnt_reg;
    assign decode_starved = (avail == 3'h0);

    // combined stream after accept: queued entries then pushes
    reg [IW-1:0] stream [0:DEPTH+1];
    integer k;
    always @* begin
        // zero fill keeps unused slots from reading as unknown
        for (k = 0; k < DEPTH + 2; k = k + 1)
            stream[k] = {IW{1'b0}};
        for (k = 0; k < DEPTH; k = k + 1)
            stream[k] = q_mem[k];
        if (acc_cnt != 2'h0)
            stream[q_cnt_reg] = push_i0;
        if (acc_cnt == 2'h2)
            stream[q_cnt_reg + 3'h1] = push_i1;
        q_cnt_next = q_cnt_reg + {1'b0, acc_cnt} - {1'b0, pull_cnt};
    end

    // each slot moves down by the number pulled
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_slot
            always @(posedge ref_clk) begin
                if (rst)
                    q_mem[g] <= {IW{1'b0}};
                else
                    q_mem[g] <= stream[g + pull_cnt];
            end
        end
    endgenerate

    always @(posedge ref_clk) begin
        if (rst)
            q_cnt_reg <= 3'h0;
        else
            q_cnt_reg <= q_cnt_next;
    end

    // decode stages advance only when not held
    always @(posedge ref_clk) begin
        if (rst) begin
            d1_u_valid_reg <= 1'b0;
            d1_v_valid_reg <= 1'b0;
            d1_u_reg       <= {IW{1'b0}};
            d1_v_reg       <= {IW{1'b0}};
            d2_u_valid_reg <= 1'b0;
            d2_v_valid_reg <= 1'b0;
            d2_u_reg       <= {IW{1'b0}};
            d2_v_reg       <= {IW{1'b0}};
        end else if (!hold) begin
            d1_u_valid_reg <= pull_cnt != 2'h0;
            d1_v_valid_reg <= pull_cnt == 2'h2;
            d1_u_reg       <= view0;
            d1_v_reg       <= view1;
            d2_u_valid_reg <= d1_u_valid_reg;
            d2_v_valid_reg <= d1_v_valid_reg;
            d2_u_reg       <= d1_u_reg;
            d2_v_reg       <= d1_v_reg;
        end
    end

    // operands read in decode-second
    assign src_addr_u = d2_u_reg[`SPI_F_SRC_HI:`SPI_F_SRC_LO];
    assign src_addr_v = d2_v_reg[`SPI_F_SRC_HI:`SPI_F_SRC_LO];

    // execute commit; a stall inserts a bubble rather than a duplicate
    always @(posedge ref_clk) begin
        if (rst) begin
            exec_u_valid_reg <= 1'b0;
            exec_v_valid_reg <= 1'b0;
            exec_u_instr_reg <= {IW{1'b0}};
            exec_v_instr_reg <= {IW{1'b0}};
            exec_u_src_reg   <= 64'h0000000000000000;
            exec_v_src_reg   <= 64'h0000000000000000;
        end else begin
            exec_u_valid_reg <= d2_u_valid_reg && !hold;
            exec_v_valid_reg <= d2_v_valid_reg && !hold;
            exec_u_instr_reg <= d2_u_reg;
            exec_v_instr_reg <= d2_v_reg;
            exec_u_src_reg   <= src_data_u;
            exec_v_src_reg   <= src_data_v;
        end
    end

    // simd execute stage; nothing here stalls
    wire u_simd = exec_u_valid_reg && exec_u_instr_reg[`SPI_F_CLS_HI:`SPI_F_CLS_LO] == `SPI_CLS_SIMD;
    wire v_simd = exec_v_valid_reg && exec_v_instr_reg[`SPI_F_CLS_HI:`SPI_F_CLS_LO] == `SPI_CLS_SIMD;
    wire u_mul = u_simd && exec_u_instr_reg[`SPI_F_MUL];
    wire v_mul = v_simd && exec_v_instr_reg[`SPI_F_MUL];

    reg       sx_u_reg;
    reg       sx_v_reg;
    reg [2:0] sx_u_dst_reg;
    reg [2:0] sx_v_dst_reg;
    always @(posedge ref_clk) begin
        if (rst) begin
            sx_u_reg     <= 1'b0;
            sx_v_reg     <= 1'b0;
            sx_u_dst_reg <= 3'h0;
            sx_v_dst_reg <= 3'h0;
        end else begin
            sx_u_reg     <= u_simd && !u_mul;
            sx_v_reg     <= v_simd && !v_mul;
            sx_u_dst_reg <= exec_u_instr_reg[`SPI_F_DST_HI:`SPI_F_DST_LO];
            sx_v_dst_reg <= exec_v_instr_reg[`SPI_F_DST_HI:`SPI_F_DST_LO];
        end
    end

    // single-clock results land in the stage after execute;
    // a port per pipe so a paired result never has to wait
    always @(posedge ref_clk) begin
        if (rst) begin
            alu_write_valid_reg   <= 1'b0;
            alu_write_dst_reg     <= 3'h0;
            alu_v_write_valid_reg <= 1'b0;
            alu_v_write_dst_reg   <= 3'h0;
        end else begin
            alu_write_valid_reg   <= sx_u_reg;
            alu_write_dst_reg     <= sx_u_dst_reg;
            alu_v_write_valid_reg <= sx_v_reg;
            alu_v_write_dst_reg   <= sx_v_dst_reg;
        end
    end

    // multiplier: three stages then write
    // one multiplier serves both pipes; pairing never feeds it twice
    reg [`SPI_MUL_STAGES-1:0] mul_v_reg;
    reg [2:0]                 mul_d_reg [0:`SPI_MUL_STAGES-1];
    integer m;
    always @(posedge ref_clk) begin
        if (rst) begin
            mul_v_reg           <= {`SPI_MUL_STAGES{1'b0}};
            mul_write_valid_reg <= 1'b0;
            mul_write_dst_reg   <= 3'h0;
            for (m = 0; m < `SPI_MUL_STAGES; m = m + 1)
                mul_d_reg[m] <= 3'h0;
        end else begin
            mul_v_reg    <= {mul_v_reg[`SPI_MUL_STAGES-2:0], u_mul || v_mul};
            mul_d_reg[0] <= u_mul ? exec_u_instr_reg[`SPI_F_DST_HI:`SPI_F_DST_LO]
                                  : exec_v_instr_reg[`SPI_F_DST_HI:`SPI_F_DST_LO];
            for (m = 1; m < `SPI_MUL_STAGES; m = m + 1)
                mul_d_reg[m] <= mul_d_reg[m-1];
            mul_write_valid_reg <= mul_v_reg[`SPI_MUL_STAGES-1];
            mul_write_dst_reg   <= mul_d_reg[`SPI_MUL_STAGES-1];
        end
    end
endmodule
`default_nettype wire

// *** bench/spi_issue_ctl_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spi_map.vh"
module spi_issue_ctl_sva #(
    parameter int DEPTH = `SPI_QUEUE_DEPTH,
    parameter int IW    = `SPI_INSTR_W
) (
    // clock and reset
    input wire logic          ref_clk,
    input wire logic          rst,
    // front end
    input wire logic [1:0]    raw_valid,
    input wire logic [3:0]    raw_len0,
    input wire logic [3:0]    raw_len1,
    input wire logic [1:0]    raw_accept,
    input wire logic [2:0]    queue_count,
    // control
    input wire logic          task_switched_bit,
    input wire logic          emulation_bit,
    input wire logic          pipe_stall,
    // execute and writes
    input wire logic          exec_u_valid_reg,
    input wire logic          exec_v_valid_reg,
    input wire logic [IW-1:0] exec_u_instr_reg,
    input wire logic [IW-1:0] exec_v_instr_reg,
    input wire logic          alu_write_valid_reg,
    input wire logic [2:0]    alu_write_dst_reg,
    input wire logic          alu_v_write_valid_reg,
    input wire logic [2:0]    alu_v_write_dst_reg,
    input wire logic          mul_write_valid_reg,
    input wire logic [2:0]    mul_write_dst_reg
);
    wire logic [IW-1:0] u  = exec_u_instr_reg;
    wire logic [IW-1:0] v  = exec_v_instr_reg;
    wire logic [2:0]    ud = u[10:8];
    wire logic          us = u[1:0] == `SPI_CLS_SIMD;
    wire logic          vs = v[1:0] == `SPI_CLS_SIMD;
    wire logic          pr = exec_u_valid_reg && exec_v_valid_reg;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_depth;
        queue_count <= DEPTH;
    endproperty
    a_depth: assert property (p_depth) else $error("queue above depth");
    property p_push;
        raw_accept[1] |-> raw_accept[0] && raw_valid == 2'h3;
    endproperty
    a_push: assert property (p_push) else $error("bad push pattern");
    property p_long;
        raw_valid == 2'h3 && (raw_len0 > 4'h7 || raw_len1 > 4'h7) |-> !raw_accept[1];
    endproperty
    a_long: assert property (p_long) else $error("long record pushed as pair");
    property p_stall;
        pipe_stall |=> !exec_u_valid_reg && !exec_v_valid_reg;
    endproperty
    a_stall: assert property (p_stall) else $error("issue during stall");
    property p_alu;
        exec_u_valid_reg && us && !u[3] && !u[5] |-> ##2 alu_write_valid_reg && alu_write_dst_reg == $past(ud, 2);
    endproperty
    a_alu: assert property (p_alu) else $error("alu write timing");
    property p_alu_v;
        exec_v_valid_reg && vs && !v[3] |-> ##2 alu_v_write_valid_reg && alu_v_write_dst_reg == $past(v[10:8], 2);
    endproperty
    a_alu_v: assert property (p_alu_v) else $error("second pipe alu write timing");
    property p_mul;
        exec_u_valid_reg && us && u[3] |-> ##4 mul_write_valid_reg && mul_write_dst_reg == $past(ud, 4);
    endproperty
    a_mul: assert property (p_mul) else $error("mul write timing");
    property p_cls;
        pr |-> !(us && v[1:0] == `SPI_CLS_FP) && !(vs && u[1:0] == `SPI_CLS_FP);
    endproperty
    a_cls: assert property (p_cls) else $error("simd paired with float");
    property p_unit;
        pr && us && vs |-> !(u[2] && v[2]) && !(u[3] && v[3]);
    endproperty
    a_unit: assert property (p_unit) else $error("shared unit paired");
    property p_dep;
        pr && us && vs |-> ud != v[13:11] && ud != v[10:8];
    endproperty
    a_dep: assert property (p_dep) else $error("dependent pair");
    property p_alone;
        pr |-> !(vs && v[4]) && !u[5] && !v[5];
    endproperty
    a_alone: assert property (p_alone) else $error("illegal second pipe use");
    property p_ctl;
        (task_switched_bit || emulation_bit) [*4] |=> !(exec_v_valid_reg && vs);
    endproperty
    a_ctl: assert property (p_ctl) else $error("simd in second pipe while blocked");
    property p_iu;
        pr && u[1:0] == `SPI_CLS_INT && vs |-> u[6] && !v[14];
    endproperty
    a_iu: assert property (p_iu) else $error("bad integer then simd pair");
    property p_su;
        pr && us && v[1:0] == `SPI_CLS_INT |-> v[7] && !u[4];
    endproperty
    a_su: assert property (p_su) else $error("bad simd then integer pair");
endmodule
bind spi_issue_ctl spi_issue_ctl_sva #(.DEPTH(DEPTH), .IW(IW)) i_sva (
    .ref_clk, .rst, .raw_valid, .raw_len0, .raw_len1, .raw_accept, .queue_count,
    .task_switched_bit, .emulation_bit, .pipe_stall, .exec_u_valid_reg, .exec_v_valid_reg,
    .exec_u_instr_reg, .exec_v_instr_reg, .alu_write_valid_reg, .alu_write_dst_reg,
    .alu_v_write_valid_reg, .alu_v_write_dst_reg,
    .mul_write_valid_reg, .mul_write_dst_reg
);
`default_nettype wire

// *** bench/spi_fetch_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_fetch_model (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // record stream
    input  wire logic [1:0]  raw_accept,
    output logic      [1:0]  raw_valid,
    output logic      [3:0]  raw_len0,
    output logic      [3:0]  raw_len1,
    output logic      [3:0]  raw_prefix0,
    output logic      [3:0]  raw_prefix1,
    output logic      [30:0] raw_instr0,
    output logic      [30:0] raw_instr1,
    // operand file
    input  wire logic [2:0]  src_addr_u,
    input  wire logic [2:0]  src_addr_v,
    output logic      [63:0] src_data_u,
    output logic      [63:0] src_data_v
);
    logic [30:0] rec [0:127] = '{default: 31'h2AAA5555};
    logic [3:0]  len [0:127] = '{default: 4'hA};
    logic [3:0]  pre [0:127] = '{default: 4'h0};
    int          n   = 0;
    int          hd  = 0;
    int          adv = 0;
    // records hold until taken; idle lanes carry inverted data, not stale copies
    always @(posedge ref_clk) begin
        adv = rst ? 0 : raw_accept[0] + raw_accept[1];
        #1;
        hd = hd + adv;
    end
    always_comb begin
        raw_valid   = (n - hd > 1) ? 2'h3 : ((n > hd) ? 2'h1 : 2'h0);
        raw_len0    = len[hd];
        raw_len1    = len[hd + 1];
        raw_prefix0 = pre[hd];
        raw_prefix1 = pre[hd + 1];
        raw_instr0  = raw_valid[0] ? rec[hd] : ~rec[hd];
        raw_instr1  = raw_valid[1] ? rec[hd + 1] : ~rec[hd + 1];
    end
    assign src_data_u = {16{1'b1, src_addr_u}};
    assign src_data_v = {16{1'b1, src_addr_v}};
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spi_map.vh"
module tb_top;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        task_switched_bit = 1'b0;
    logic        emulation_bit = 1'b0;
    logic        pipe_stall = 1'b0;
    logic [1:0]  raw_valid, raw_accept;
    logic [3:0]  raw_len0, raw_len1, raw_prefix0, raw_prefix1;
    logic [30:0] raw_instr0, raw_instr1, exec_u_instr_reg, exec_v_instr_reg;
    logic [2:0]  src_addr_u, src_addr_v, alu_write_dst_reg, mul_write_dst_reg, queue_count, alu_v_write_dst_reg;
    logic [63:0] src_data_u, src_data_v, exec_u_src_reg, exec_v_src_reg;
    logic        exec_u_valid_reg, exec_v_valid_reg, alu_write_valid_reg, mul_write_valid_reg, alu_v_write_valid_reg;
    logic        decode_starved;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          nid = 0;
    int          eid = 0;

    always #20 ref_clk = ~ref_clk;

    spi_fetch_model i_src (.ref_clk, .rst, .raw_accept, .raw_valid, .raw_len0, .raw_len1,
        .raw_prefix0, .raw_prefix1, .raw_instr0, .raw_instr1, .src_addr_u, .src_addr_v,
        .src_data_u, .src_data_v);
    spi_issue_ctl i_dut (.ref_clk, .rst, .raw_valid, .raw_len0, .raw_len1, .raw_prefix0,
        .raw_prefix1, .raw_instr0, .raw_instr1, .raw_accept, .task_switched_bit, .emulation_bit,
        .pipe_stall, .src_addr_u, .src_addr_v, .src_data_u, .src_data_v, .exec_u_valid_reg,
        .exec_v_valid_reg, .exec_u_instr_reg, .exec_v_instr_reg, .exec_u_src_reg, .exec_v_src_reg,
        .alu_write_valid_reg, .alu_write_dst_reg, .mul_write_valid_reg, .mul_write_dst_reg,
        .alu_v_write_valid_reg, .alu_v_write_dst_reg,
        .queue_count, .decode_starved);

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    // opcode field carries a running id so issue order can be followed
    task automatic ld(input logic [14:0] lo, input logic [3:0] ln, input logic [3:0] pf);
        i_src.rec[i_src.n] = {nid[15:0], lo};
        i_src.len[i_src.n] = ln;
        i_src.pre[i_src.n] = pf;
        i_src.n++;
        nid++;
    endtask

    // every issued instruction must be the next one in program order
    always @(posedge ref_clk) begin
        #2;
        if (exec_u_valid_reg === 1'b1) begin
            chk(exec_u_instr_reg[26:15], eid[11:0]);
            eid++;
        end
        if (exec_v_valid_reg === 1'b1) begin
            chk(exec_v_instr_reg[26:15], eid[11:0]);
            eid++;
        end
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic pr(input logic [14:0] a, b, input logic ex, input logic [1:0] ctl);
        task_switched_bit = ctl[1];
        emulation_bit     = ctl[0];
        ld(a, 4'h2, 4'h0);
        ld(b, 4'h2, 4'h0);
        step(3);
        chk(exec_u_valid_reg, 1'b1);
        chk(exec_u_src_reg, {16{1'b1, a[13:11]}});
        chk(exec_v_valid_reg, ex);
        if (ex)
            chk(exec_v_src_reg, {16{1'b1, b[13:11]}});
        if (!ex) begin
            step(1);
            chk(exec_u_instr_reg[14:0], b);
        end
        step(6);
    endtask
    task automatic t_pairs;
        pr(15'h1101, 15'h2301, 1'b1, 2'h0);
        pr(15'h1101, 15'h0002, 1'b0, 2'h0);
        pr(15'h0002, 15'h2301, 1'b0, 2'h0);
        pr(15'h1105, 15'h2305, 1'b0, 2'h0);
        pr(15'h1109, 15'h2309, 1'b0, 2'h0);
        pr(15'h1101, 15'h2311, 1'b0, 2'h0);
        pr(15'h1101, 15'h0B01, 1'b0, 2'h0);
        pr(15'h1101, 15'h2101, 1'b0, 2'h0);
        pr(15'h1121, 15'h2301, 1'b0, 2'h0);
        pr(15'h1101, 15'h2321, 1'b0, 2'h0);
        pr(15'h1101, 15'h2301, 1'b0, 2'h2);
        pr(15'h1101, 15'h2301, 1'b0, 2'h1);
        pr(15'h0040, 15'h2301, 1'b1, 2'h0);
        pr(15'h0000, 15'h2301, 1'b0, 2'h0);
        pr(15'h0040, 15'h6301, 1'b0, 2'h0);
        pr(15'h0040, 15'h2311, 1'b0, 2'h0);
        pr(15'h1101, 15'h0080, 1'b1, 2'h0);
        pr(15'h1101, 15'h0000, 1'b0, 2'h0);
        pr(15'h1111, 15'h0080, 1'b0, 2'h0);
    endtask
    task automatic t_single;
        ld(15'h1101, 4'h3, 4'h5);
        step(3);
        chk(exec_u_instr_reg[30:27], 4'h5);
        chk(exec_v_valid_reg, 1'b0);
        step(6);
    endtask
    task automatic lg(input logic [3:0] l0, l1, input logic [1:0] ex);
        ld(15'h1101, l0, 4'h0);
        ld(15'h2301, l1, 4'h0);
        #5;
        chk(raw_accept, ex);
        step(8);
    endtask
    // held decode lets the queue fill; afterwards it must drain a pair per cycle
    task automatic t_fill;
        pipe_stall = 1'b1;
        for (int i = 0; i < 8; i++) ld({1'b0, i[2:0], i[2:0], 8'h01}, 4'h2, 4'h0);
        step(10);
        chk(queue_count, 3'h4);
        chk(raw_accept, 2'h0);
        pipe_stall = 1'b0;
        for (int w = 0; w < 10 && exec_u_valid_reg !== 1'b1; w++) step(1);
        for (int k = 0; k < 4; k++) begin
            chk(exec_v_valid_reg, 1'b1);
            step(1);
        end
        step(3);
        chk(decode_starved, 1'b1);
        chk(exec_u_valid_reg, 1'b0);
        chk(eid, nid);
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        step(1);
        t_single();
        t_pairs();
        lg(4'h8, 4'h2, 2'h1);
        lg(4'h2, 4'h8, 2'h1);
        lg(4'h7, 4'h7, 2'h3);
        t_fill();
        print_verdict();
    end
endmodule
`default_nettype wire
